// ### include/lss_pkg.sv
// Shared constants of the light sensor status and refresh block.
// Assumes a 50 MHz system clock and a command-code register port.
package lss_pkg;

   // ----------------------------------------------------------------
   // Command codes and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_POWER_SAVE   = 8'h03;
   localparam logic [7:0]  CMD_WHITE_RESULT = 8'h05;
   localparam logic [7:0]  CMD_EVENT_FLAGS  = 8'h06;

   localparam int          BELOW_FLAG_BIT   = 15;
   localparam int          ABOVE_FLAG_BIT   = 14;
   localparam int          PS_ENABLE_BIT    = 0;
   localparam int          PS_SEL_LSB       = 1;
   localparam int          PS_SEL_MSB       = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic        PS_ENABLE_RESET  = 1'b0;
   localparam logic [1:0]  PS_SEL_RESET     = 2'h0;
   localparam logic [15:0] WHITE_RESET      = 16'h0000;
   localparam logic [15:0] READ_IDLE        = 16'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS    = 20;
   localparam int          MS_NS            = 1000000;
   localparam int          MS_TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

   // Power-save period selection encodings
   typedef enum logic [1:0] {
      PS_MODE1 = 2'b00,
      PS_MODE2 = 2'b01,
      PS_MODE3 = 2'b10,
      PS_MODE4 = 2'b11
   } lss_ps_mode_e;

   // Integration time codes with a tabled refresh period
   localparam logic [3:0]  IT_CODE0         = 4'h0;
   localparam logic [3:0]  IT_CODE1         = 4'h1;
   localparam logic [3:0]  IT_CODE2         = 4'h2;
   localparam logic [3:0]  IT_CODE3         = 4'h3;

   // Mode 1 refresh periods in ms: 600, 700, 900, 1300
   localparam logic [15:0] BASE_IT0_MS      = 16'h0258;
   localparam logic [15:0] BASE_IT1_MS      = 16'h02bc;
   localparam logic [15:0] BASE_IT2_MS      = 16'h0384;
   localparam logic [15:0] BASE_IT3_MS      = 16'h0514;

   // Extra ms per mode: 0, 500, 1500, 3500
   localparam logic [15:0] ADD_MODE1_MS     = 16'h0000;
   localparam logic [15:0] ADD_MODE2_MS     = 16'h01f4;
   localparam logic [15:0] ADD_MODE3_MS     = 16'h05dc;
   localparam logic [15:0] ADD_MODE4_MS     = 16'h0dac;

endpackage

// ### rtl/lss_pulse_div.sv
// Counting divider: one-cycle pulse after limit enabled cycles.
// Assumes limit is at least one; a limit of zero acts as one.
`timescale 1ns/1ps
module lss_pulse_div (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        step,
   input  wire logic [15:0] limit,
   output logic             pulse_q
);
   import lss_pkg::*;

   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        pulse_d;

   always_comb begin
      count_d = count_q;
      pulse_d = 1'b0;
      if (restart) begin
         count_d = 16'h0000;
      end else if (step) begin
         // A shrunken limit must not let the count run past it
         if (count_q + 16'h0001 >= limit) begin
            count_d = 16'h0000;
            pulse_d = 1'b1;
         end else begin
            count_d = count_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= 16'h0000;
         pulse_q <= 1'b0;
      end else begin
         count_q <= count_d;
         pulse_q <= pulse_d;
      end
   end

endmodule

// ### rtl/lss_status_refresh.sv
// Result, event-flag and refresh-period logic of the light sensor.
// Assumes the command front end, the converter and the threshold
// registers share clk; all inputs are same-domain logic.
`timescale 1ns/1ps
module lss_status_refresh #(
   parameter int unsigned TICK_CYCLES = lss_pkg::MS_TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   input  wire logic        rd_en,
   output logic [15:0]      rd_data_q,
   output logic             rd_valid_q,
   input  wire logic [15:0] sample_data,
   input  wire logic [15:0] low_threshold,
   input  wire logic [15:0] high_threshold,
   input  wire logic        threshold_int_enable,
   input  wire logic [3:0]  integration_time_code,
   output logic             measure_strobe_q,
   output logic             power_save_enable_q,
   output logic [1:0]       power_save_period_sel_q
);
   import lss_pkg::*;

   // ----------------------------------------------------------------
   // Power-save register
   // ----------------------------------------------------------------
   logic       power_save_enable_d;
   logic [1:0] power_save_period_sel_d;
   logic       ps_write;

   always_comb begin
      ps_write                = wr_en && (cmd_code == CMD_POWER_SAVE);
      power_save_enable_d     = power_save_enable_q;
      power_save_period_sel_d = power_save_period_sel_q;
      if (ps_write) begin
         power_save_enable_d     = wr_data[PS_ENABLE_BIT];
         power_save_period_sel_d = wr_data[PS_SEL_MSB:PS_SEL_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         power_save_enable_q     <= PS_ENABLE_RESET;
         power_save_period_sel_q <= PS_SEL_RESET;
      end else begin
         power_save_enable_q     <= power_save_enable_d;
         power_save_period_sel_q <= power_save_period_sel_d;
      end
   end

   // ----------------------------------------------------------------
   // Refresh period selection
   // ----------------------------------------------------------------
   logic [15:0] base_ms;
   logic [15:0] add_ms;
   logic [15:0] period_ms;

   always_comb begin
      // Untabled integration codes fall back to the shortest period
      case (integration_time_code)
         IT_CODE0: base_ms = BASE_IT0_MS;
         IT_CODE1: base_ms = BASE_IT1_MS;
         IT_CODE2: base_ms = BASE_IT2_MS;
         IT_CODE3: base_ms = BASE_IT3_MS;
         default:  base_ms = BASE_IT0_MS;
      endcase
      case (lss_ps_mode_e'(power_save_period_sel_q))
         PS_MODE1: add_ms = ADD_MODE1_MS;
         PS_MODE2: add_ms = ADD_MODE2_MS;
         PS_MODE3: add_ms = ADD_MODE3_MS;
         PS_MODE4: add_ms = ADD_MODE4_MS;
         default:  add_ms = ADD_MODE1_MS;
      endcase
      // Mode adder only counts with power saving on
      if (power_save_enable_q) begin
         period_ms = base_ms + add_ms;
      end else begin
         period_ms = base_ms;
      end
   end

   // ----------------------------------------------------------------
   // Millisecond tick and refresh timer
   // ----------------------------------------------------------------
   logic ms_tick;
   logic refresh_tick;
   logic [15:0] tick_limit;
   logic [3:0]  it_code_q;
   logic [3:0]  it_code_d;
   logic        period_restart;

   assign tick_limit = TICK_CYCLES[15:0];

   lss_pulse_div u_ms_div (
      .clk     (clk),
      .rst     (rst),
      .restart (1'b0),
      .step    (1'b1),
      .limit   (tick_limit),
      .pulse_q (ms_tick)
   );

   // A new setting starts a fresh full period rather than a short one
   always_comb begin
      it_code_d      = integration_time_code;
      period_restart = ps_write || (it_code_q != integration_time_code);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         it_code_q <= 4'h0;
      end else begin
         it_code_q <= it_code_d;
      end
   end

   lss_pulse_div u_refresh_div (
      .clk     (clk),
      .rst     (rst),
      .restart (period_restart),
      .step    (ms_tick),
      .limit   (period_ms),
      .pulse_q (refresh_tick)
   );

   // ----------------------------------------------------------------
   // Result capture and event flags
   // ----------------------------------------------------------------
   logic [15:0] white_result_q;
   logic [15:0] white_result_d;
   logic        below_window_flag_q;
   logic        below_window_flag_d;
   logic        above_window_flag_q;
   logic        above_window_flag_d;
   logic        measure_strobe_d;
   logic        flags_read;
   logic        below_hit;
   logic        above_hit;

   always_comb begin
      flags_read       = rd_en && (cmd_code == CMD_EVENT_FLAGS);
      below_hit        = refresh_tick && threshold_int_enable
                         && (sample_data < low_threshold);
      above_hit        = refresh_tick && threshold_int_enable
                         && (sample_data > high_threshold);
      measure_strobe_d = refresh_tick;
      white_result_d   = white_result_q;
      if (refresh_tick) begin
         white_result_d = sample_data;
      end
      // Reading the flags clears them; a crossing in the same cycle wins
      below_window_flag_d = below_window_flag_q;
      above_window_flag_d = above_window_flag_q;
      if (flags_read) begin
         below_window_flag_d = 1'b0;
         above_window_flag_d = 1'b0;
      end
      if (below_hit) begin
         below_window_flag_d = 1'b1;
      end
      if (above_hit) begin
         above_window_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         white_result_q      <= WHITE_RESET;
         below_window_flag_q <= 1'b0;
         above_window_flag_q <= 1'b0;
         measure_strobe_q    <= 1'b0;
      end else begin
         white_result_q      <= white_result_d;
         below_window_flag_q <= below_window_flag_d;
         above_window_flag_q <= above_window_flag_d;
         measure_strobe_q    <= measure_strobe_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [15:0] rd_data_d;
   logic        rd_valid_d;

   always_comb begin
      rd_valid_d = rd_en;
      rd_data_d  = READ_IDLE;
      if (rd_en) begin
         case (cmd_code)
            CMD_WHITE_RESULT: rd_data_d = white_result_q;
            CMD_EVENT_FLAGS: begin
               rd_data_d                 = READ_IDLE;
               rd_data_d[BELOW_FLAG_BIT] = below_window_flag_q;
               rd_data_d[ABOVE_FLAG_BIT] = above_window_flag_q;
            end
            CMD_POWER_SAVE: begin
               rd_data_d                         = READ_IDLE;
               rd_data_d[PS_ENABLE_BIT]          = power_save_enable_q;
               rd_data_d[PS_SEL_MSB:PS_SEL_LSB]  = power_save_period_sel_q;
            end
            default: rd_data_d = READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q  <= READ_IDLE;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

endmodule

// ### dv/lss_status_refresh_properties.sv
// Assertions on the command port and the refresh strobe.
// Assumes it is bound to lss_status_refresh; one clock.
`timescale 1ns/1ps
module lss_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  cmd_code,
   input wire logic        wr_en,
   input wire logic [15:0] wr_data,
   input wire logic        rd_en,
   input wire logic [15:0] rd_data_q,
   input wire logic        rd_valid_q,
   input wire logic        measure_strobe_q,
   input wire logic        power_save_enable_q,
   input wire logic [1:0]  power_save_period_sel_q
);
   // ----
   // Properties
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (rd_en |=> rd_valid_q)
      else $error("read unanswered");
   chk_idle_zero: assert property (!rd_en |=> !rd_valid_q && rd_data_q == 16'h0000)
      else $error("answer without read");
   chk_flag_reserved: assert property (
      rd_en && cmd_code == 8'h06 |=> rd_data_q[13:0] == 14'h0000) else $error("reserved set");
   chk_ps_write: assert property (
      wr_en && cmd_code == 8'h03 |=> power_save_enable_q == $past(wr_data[0])
      && power_save_period_sel_q == $past(wr_data[2:1])) else $error("write lost");
   chk_ps_readback: assert property (
      rd_en && !wr_en && cmd_code == 8'h03 |=> rd_data_q == {13'h0000,
      $past(power_save_period_sel_q), $past(power_save_enable_q)}) else $error("bad readback");
   chk_strobe_pulse: assert property (measure_strobe_q |=> !measure_strobe_q [*8])
      else $error("strobe too long");
   // A tick at the write edge may still show, so the quiet span starts later
   chk_restart_gap: assert property (
      wr_en && cmd_code == 8'h03 |-> ##2 !measure_strobe_q [*8]) else $error("no restart");
   chk_reset_idle: assert property ($fell(rst) |-> !rd_valid_q && !measure_strobe_q
      && !power_save_enable_q && power_save_period_sel_q == 2'b00) else $error("not idle");
endmodule
bind lss_status_refresh lss_chk u_chk (.clk(clk), .rst(rst), .cmd_code(cmd_code),
   .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data_q(rd_data_q),
   .rd_valid_q(rd_valid_q), .measure_strobe_q(measure_strobe_q),
   .power_save_enable_q(power_save_enable_q),
   .power_save_period_sel_q(power_save_period_sel_q));

// ### dv/lss_host_model.sv
// Host side of the command port: one read or write at a time.
// Assumes requests change on falling edges, answers one edge later.
`timescale 1ns/1ps
module lss_host_model (
   input  wire logic        clk,
   output logic [7:0]       cmd_code,
   output logic             wr_en,
   output logic [15:0]      wr_data,
   output logic             rd_en,
   input  wire logic [15:0] rd_data_q,
   input  wire logic        rd_valid_q
);
   // ----
   // Access tasks
   // ----
   initial {cmd_code, wr_en, wr_data, rd_en} = '0;
   // Bit 0 enable, bits 2:1 mode, the rest reserved
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge clk);
      cmd_code = c;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Result and flags are only read, never written back
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
      @(negedge clk);
      cmd_code = c;
      rd_en = 1'b1;
      @(negedge clk);
      d = rd_data_q;
      v = rd_valid_q;
      rd_en = 1'b0;
   endtask
endmodule

// ### dv/test_light_sensor_status_and_refresh.sv
// Self-checking bench: command port, event flags, refresh periods.
// Assumes the host model on the command port; a ms lasts TK clocks.
`timescale 1ns/1ps
module test_light_sensor_status_and_refresh;
   import lss_pkg::*;
   localparam int TK = 4;
   logic        clk = 1'b0, rst = 1'b1, wr_en, rd_en, rd_valid_q, measure_strobe_q;
   logic        power_save_enable_q, threshold_int_enable = 1'b0;
   logic [1:0]  power_save_period_sel_q;
   logic [3:0]  integration_time_code = 4'h0;
   logic [7:0]  cmd_code;
   logic [15:0] wr_data, rd_data_q, sample_data = 16'h0000;
   logic [15:0] low_threshold = 16'h0000, high_threshold = 16'hffff;
   int          err_count = 0, tests_run = 0;
   int          base_ms[4] = '{600, 700, 900, 1300};
   int          add_ms[$] = '{0, 500, 1500, 3500};
   always #10 clk = ~clk;
   lss_host_model u_host (.clk(clk), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data),
      .rd_en(rd_en), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
   lss_status_refresh #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .rst(rst), .cmd_code(cmd_code),
      .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .sample_data(sample_data), .low_threshold(low_threshold),
      .high_threshold(high_threshold), .threshold_int_enable(threshold_int_enable),
      .integration_time_code(integration_time_code), .measure_strobe_q(measure_strobe_q),
      .power_save_enable_q(power_save_enable_q),
      .power_save_period_sel_q(power_save_period_sel_q));
   // ----
   // Helpers and sequence
   // ----
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      u_host.rd(c, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, exp);
   endtask
   task automatic wait_strobe(output int n);
      for (n = 1; n < 20000; n++) begin
         @(negedge clk);
         if (measure_strobe_q === 1'b1) break;
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      int          n, s, p;
      logic [1:0]  m;
      logic [15:0] d, fl;
      void'($urandom(32'h90a1667e));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      rd_chk(CMD_POWER_SAVE, 16'h0000);
      rd_chk(CMD_WHITE_RESULT, 16'h0000);
      rd_chk(CMD_EVENT_FLAGS, 16'h0000);
      rd_chk(8'h07, READ_IDLE);
      // Each mode code with junk in the reserved bits, then a write that must not land
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         d[2:0] = {i[1:0], 1'b1};
         u_host.wr(CMD_POWER_SAVE, d);
         u_host.wr(i[0] ? CMD_WHITE_RESULT : CMD_EVENT_FLAGS, ~d);
         chk(16'(power_save_period_sel_q), 16'(i));
         rd_chk(CMD_POWER_SAVE, {13'h0000, d[2:0]});
      end
      // Below, above, disabled, and samples equal to both bounds
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 2'b11 : i[1:0];
         p = base_ms[i] + ((i == 0) ? 0 : add_ms[m]);
         s = $urandom_range(16'hfffe, 1);
         sample_data = 16'(s);
         threshold_int_enable = (i != 2);
         low_threshold = (i == 1) ? 16'h0000 : 16'(s + ((i == 3) ? 0 : 1));
         high_threshold = (i == 1) ? 16'(s - 1) : (i == 3) ? 16'(s) : 16'hffff;
         fl = (i == 0) ? 16'h8000 : (i == 1) ? 16'h4000 : 16'h0000;
         integration_time_code = 4'(i);
         u_host.wr(CMD_POWER_SAVE, {13'h0000, m, i != 0});
         wait_strobe(n);
         wait_strobe(n);
         chk(16'(n), 16'(p * TK));
         rd_chk(CMD_WHITE_RESULT, 16'(s));
         rd_chk(CMD_EVENT_FLAGS, fl);
         rd_chk(CMD_EVENT_FLAGS, 16'h0000);
      end
      // An untabled integration code falls back to the shortest base period
      integration_time_code = 4'h9;
      u_host.wr(CMD_POWER_SAVE, 16'h0000);
      wait_strobe(n);
      wait_strobe(n);
      chk(16'(n), 16'(base_ms[0] * TK));
      conclude();
   end
   // The five refresh checks take about 77000 cycles
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule
